// [design/mste_engine.sv]
// memory stack and table engine: stack, range and record-table commands
`timescale 1ns/10ps
module mste_engine (
  input logic core_clk, // 250 MHz clock
  input logic rst, // synchronous reset, active high
  input logic cmd_valid, // command offered
  output logic cmd_ready, // engine idle, takes command
  input mste_pkg::mste_cmd_t cmd, // command fields
  output mste_pkg::mste_mem_t mem, // memory request
  input logic [15:0] mem_rdata, // read data, one cycle after rd
  input logic ir_wr, // program writes an index register
  input logic [3:0] ir_wr_sel, // index register written
  input logic [31:0] ir_wr_data, // value written
  input logic [3:0] ir_rd_sel, // index register read
  output logic [31:0] ir_rd_data, // selected index register
  output logic [31:0] result_index_register, // index register zero
  output logic done, // command finished, one cycle
  output logic err, // last command refused or failed
  output logic [31:0] result // last command result
);
  import mste_pkg::*;

  mste_state_t s_r;
  mste_state_t s_nxt;
  logic [31:0] fa;
  logic [31:0] pa;
  logic [15:0] cnt;
  logic [15:0] sp;
  logic is_range;
  logic is_rec;
  logic is_stk;
  logic hit;

  always_comb begin
    s_nxt = s_r;
    fa = s_r.c.addr + MSTE_HDR_WORDS;
    // pointer word keeps the low half; region stays inside one page
    pa = {s_r.c.addr[31:16], s_r.ptr};
    cnt = s_r.ptr - fa[15:0];
    sp = (s_r.c.op == MSTE_OP_FIFO) ? 16'h0 :
         (s_r.c.op == MSTE_OP_LIFO) ? cnt - 16'h1 : s_r.c.pos;
    is_range = s_r.c.op inside {MSTE_OP_FIND, MSTE_OP_MAX, MSTE_OP_MIN,
                                MSTE_OP_SUM, MSTE_OP_CSUM};
    is_rec = s_r.c.op inside {MSTE_OP_RDEF, MSTE_OP_RADR, MSTE_OP_RNUM};
    is_stk = !is_range && !is_rec && s_r.c.op != MSTE_OP_DEF_STACK;
    hit = 1'b0;
    // program writes first so the engine's own load wins a clash
    if (ir_wr) begin
      s_nxt.ir[ir_wr_sel] = ir_wr_data;
    end
    unique case (s_r.st)
      MSTE_ST_IDLE: if (cmd_valid) begin
        s_nxt.c = cmd;
        s_nxt.ph = MSTE_PH_A;
        s_nxt.err = 1'b0;
        s_nxt.found = 1'b0;
        s_nxt.i = 16'h0;
        s_nxt.acc = 32'h0;
        s_nxt.cur = cmd.addr;
        s_nxt.st = MSTE_ST_EXEC;
      end
      MSTE_ST_RD: s_nxt.st = MSTE_ST_CAP;
      MSTE_ST_CAP: begin
        s_nxt.rdat = mem_rdata;
        s_nxt.st = MSTE_ST_EXEC;
      end
      MSTE_ST_WR: s_nxt.st = MSTE_ST_EXEC;
      MSTE_ST_DONE: s_nxt.st = MSTE_ST_IDLE;
      MSTE_ST_EXEC: begin
        if (is_range) begin
          if (s_r.ph == MSTE_PH_A) begin
            if (s_r.i < s_r.c.len) begin
              s_nxt.maddr = s_r.cur;
              s_nxt.st = MSTE_ST_RD;
              s_nxt.ph = MSTE_PH_B;
            end else begin
              s_nxt.st = MSTE_ST_DONE;
              if (s_r.c.op inside {MSTE_OP_SUM, MSTE_OP_CSUM}) begin
                s_nxt.result = s_r.acc;
              end else begin
                s_nxt.result = {16'h0, s_r.best};
                s_nxt.err = !s_r.found;
                if (s_r.found) begin
                  s_nxt.ir[0] = s_r.besta;
                end
              end
            end
          end else begin
            unique case (s_r.c.op)
              MSTE_OP_FIND: hit = !s_r.found && s_r.rdat == s_r.c.data;
              MSTE_OP_MAX: hit = !s_r.found || s_r.rdat > s_r.best;
              MSTE_OP_MIN: hit = !s_r.found || s_r.rdat < s_r.best;
              default: hit = 1'b0;
            endcase
            if (hit) begin
              s_nxt.found = 1'b1;
              s_nxt.best = s_r.rdat;
              s_nxt.besta = s_r.cur;
            end
            if (s_r.c.op == MSTE_OP_SUM) begin
              s_nxt.acc = s_r.acc + {16'h0, s_r.rdat};
            end else begin
              s_nxt.acc = s_r.acc ^ {16'h0, s_r.rdat};
            end
            s_nxt.i = s_r.i + 16'h1;
            s_nxt.cur = s_r.cur + 32'h1;
            s_nxt.ph = MSTE_PH_A;
          end
        end else if (is_rec) begin
          unique case (s_r.c.op)
            MSTE_OP_RDEF: begin
              s_nxt.rec_base = s_r.c.addr;
              s_nxt.rec_len = s_r.c.len;
              s_nxt.rec_cnt = s_r.c.pos;
              s_nxt.err = s_r.c.len == 16'h0;
              s_nxt.st = MSTE_ST_DONE;
            end
            MSTE_OP_RADR: begin
              if (s_r.c.pos >= s_r.rec_cnt) begin
                s_nxt.err = 1'b1;
              end else begin
                s_nxt.ir[s_r.c.sel] = s_r.rec_base +
                  32'(s_r.c.pos) * 32'(s_r.rec_len);
              end
              s_nxt.st = MSTE_ST_DONE;
            end
            default: begin
              // walks records one by one; avoids a divider
              if (s_r.ph == MSTE_PH_A) begin
                s_nxt.cur = s_r.rec_base;
                s_nxt.ph = MSTE_PH_B;
              end else if (s_r.rec_len == 16'h0 ||
                           s_r.ir[s_r.c.sel] < s_r.cur ||
                           s_r.i >= s_r.rec_cnt) begin
                s_nxt.err = 1'b1;
                s_nxt.st = MSTE_ST_DONE;
              end else if (s_r.ir[s_r.c.sel] <
                           s_r.cur + {16'h0, s_r.rec_len}) begin
                s_nxt.result = {16'h0, s_r.i};
                s_nxt.st = MSTE_ST_DONE;
              end else begin
                s_nxt.cur = s_r.cur + {16'h0, s_r.rec_len};
                s_nxt.i = s_r.i + 16'h1;
              end
            end
          endcase
        end else if (!is_stk) begin
          s_nxt.st = MSTE_ST_WR;
          s_nxt.ph = s_r.ph + 4'h1;
          unique case (s_r.ph)
            MSTE_PH_A: begin
              s_nxt.maddr = s_r.c.addr + MSTE_HDR_END_LO;
              s_nxt.mwd = s_r.c.last[15:0];
              if (s_r.c.last < fa) begin
                s_nxt.err = 1'b1;
                s_nxt.st = MSTE_ST_DONE;
              end
            end
            MSTE_PH_B: begin
              s_nxt.maddr = s_r.c.addr + MSTE_HDR_END_HI;
              s_nxt.mwd = s_r.c.last[31:16];
            end
            MSTE_PH_C: begin
              s_nxt.maddr = s_r.c.addr + MSTE_HDR_PTR;
              s_nxt.mwd = fa[15:0];
            end
            default: s_nxt.st = MSTE_ST_DONE;
          endcase
        end else begin
          unique case (s_r.ph)
            MSTE_PH_A, MSTE_PH_B, MSTE_PH_C: begin
              if (s_r.ph == MSTE_PH_B) begin
                s_nxt.endaddr[15:0] = s_r.rdat;
              end
              if (s_r.ph == MSTE_PH_C) begin
                s_nxt.endaddr[31:16] = s_r.rdat;
              end
              s_nxt.maddr = s_r.c.addr + {28'h0, s_r.ph};
              s_nxt.st = MSTE_ST_RD;
              s_nxt.ph = s_r.ph + 4'h1;
            end
            MSTE_PH_D: begin
              s_nxt.ptr = s_r.rdat;
              s_nxt.ph = MSTE_PH_DISP;
            end
            MSTE_PH_DISP: begin
              s_nxt.st = MSTE_ST_DONE;
              unique case (s_r.c.op)
                MSTE_OP_PUSH: if (pa > s_r.endaddr) begin
                  s_nxt.err = 1'b1;
                end else begin
                  s_nxt.maddr = pa;
                  s_nxt.mwd = s_r.c.data;
                  s_nxt.ptr = s_r.ptr + 16'h1;
                  s_nxt.st = MSTE_ST_WR;
                  s_nxt.ph = MSTE_PH_PTRW;
                end
                MSTE_OP_COUNT: s_nxt.result = {16'h0, cnt};
                MSTE_OP_READ, MSTE_OP_WRITE: if (s_r.c.pos >= cnt) begin
                  s_nxt.err = 1'b1;
                end else begin
                  s_nxt.maddr = fa + {16'h0, s_r.c.pos};
                  s_nxt.mwd = s_r.c.data;
                  if (s_r.c.op == MSTE_OP_WRITE) begin
                    s_nxt.st = MSTE_ST_WR;
                    s_nxt.ph = MSTE_PH_FIN;
                  end else begin
                    s_nxt.st = MSTE_ST_RD;
                    s_nxt.ph = MSTE_PH_RES;
                  end
                end
                MSTE_OP_INSERT: if (pa > s_r.endaddr ||
                                    s_r.c.pos > cnt) begin
                  s_nxt.err = 1'b1;
                end else begin
                  s_nxt.cur = pa - 32'h1;
                  s_nxt.st = MSTE_ST_EXEC;
                  s_nxt.ph = MSTE_PH_SHU;
                end
                default: if (sp >= cnt) begin
                  s_nxt.err = 1'b1;
                end else begin
                  // last-in is a delete of the top entry: no shift
                  s_nxt.maddr = fa + {16'h0, sp};
                  s_nxt.cur = fa + {16'h0, sp} + 32'h1;
                  s_nxt.st = MSTE_ST_RD;
                  s_nxt.ph = MSTE_PH_DEL;
                end
              endcase
            end
            MSTE_PH_DEL: begin
              s_nxt.result = {16'h0, s_r.rdat};
              s_nxt.ph = MSTE_PH_SHD;
            end
            MSTE_PH_SHD: if (s_r.cur < pa) begin
              s_nxt.maddr = s_r.cur;
              s_nxt.st = MSTE_ST_RD;
              s_nxt.ph = MSTE_PH_SHD2;
            end else begin
              s_nxt.ptr = s_r.ptr - 16'h1;
              s_nxt.ph = MSTE_PH_PTRW;
            end
            MSTE_PH_SHD2: begin
              s_nxt.maddr = s_r.cur - 32'h1;
              s_nxt.mwd = s_r.rdat;
              s_nxt.cur = s_r.cur + 32'h1;
              s_nxt.st = MSTE_ST_WR;
              s_nxt.ph = MSTE_PH_SHD;
            end
            MSTE_PH_SHU: if (s_r.cur >= fa + {16'h0, s_r.c.pos}) begin
              s_nxt.maddr = s_r.cur;
              s_nxt.st = MSTE_ST_RD;
              s_nxt.ph = MSTE_PH_SHU2;
            end else begin
              s_nxt.maddr = fa + {16'h0, s_r.c.pos};
              s_nxt.mwd = s_r.c.data;
              s_nxt.ptr = s_r.ptr + 16'h1;
              s_nxt.st = MSTE_ST_WR;
              s_nxt.ph = MSTE_PH_PTRW;
            end
            MSTE_PH_SHU2: begin
              s_nxt.maddr = s_r.cur + 32'h1;
              s_nxt.mwd = s_r.rdat;
              s_nxt.cur = s_r.cur - 32'h1;
              s_nxt.st = MSTE_ST_WR;
              s_nxt.ph = MSTE_PH_SHU;
            end
            MSTE_PH_PTRW: begin
              s_nxt.maddr = s_r.c.addr + MSTE_HDR_PTR;
              s_nxt.mwd = s_r.ptr;
              s_nxt.st = MSTE_ST_WR;
              s_nxt.ph = MSTE_PH_FIN;
            end
            MSTE_PH_RES: begin
              s_nxt.result = {16'h0, s_r.rdat};
              s_nxt.st = MSTE_ST_DONE;
            end
            default: s_nxt.st = MSTE_ST_DONE;
          endcase
        end
      end
      default: s_nxt.st = MSTE_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= MSTE_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready = s_r.st == MSTE_ST_IDLE;
  assign done = s_r.st == MSTE_ST_DONE;
  assign err = s_r.err;
  assign result = s_r.result;
  assign ir_rd_data = s_r.ir[ir_rd_sel];
  assign result_index_register = s_r.ir[0];
  assign mem.rd = s_r.st == MSTE_ST_RD;
  assign mem.wr = s_r.st == MSTE_ST_WR;
  assign mem.addr = s_r.maddr;
  assign mem.wdata = s_r.mwd;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_accept;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_hdr_reads;
    (mem.rd && mem.addr == s_r.c.addr + MSTE_HDR_END_LO) ##3
    (mem.rd && mem.addr == s_r.c.addr + MSTE_HDR_END_HI) ##3
    (mem.rd && mem.addr == s_r.c.addr + MSTE_HDR_PTR);
  endsequence

  a_hdr_reads: assert property (
    s_accept ##1 is_stk |-> ##1 s_hdr_reads)
    else $error("stack header not read in order");
  a_def_ptr: assert property (
    mem.wr && s_r.c.op == MSTE_OP_DEF_STACK && s_r.ph == MSTE_PH_D
    |-> mem.addr == s_r.c.addr + MSTE_HDR_PTR && mem.wdata == fa[15:0])
    else $error("region pointer not set to first entry");
  a_push_refuse: assert property (
    s_r.st == MSTE_ST_EXEC && is_stk && s_r.ph == MSTE_PH_DISP &&
    s_r.c.op == MSTE_OP_PUSH && pa > s_r.endaddr
    |=> done && err ##1 !mem.wr)
    else $error("full push not refused");
  a_push_store: assert property (
    s_r.st == MSTE_ST_EXEC && is_stk && s_r.ph == MSTE_PH_DISP &&
    s_r.c.op == MSTE_OP_PUSH && pa <= s_r.endaddr
    |=> mem.wr && mem.addr == $past(pa) &&
    s_r.ptr == $past(s_r.ptr) + 16'h1 ##2 mem.wr && mem.wdata == s_r.ptr)
    else $error("push store or pointer update wrong");
  a_lifo_keep: assert property (
    s_r.c.op == MSTE_OP_LIFO && mem.wr
    |-> mem.addr == s_r.c.addr + MSTE_HDR_PTR)
    else $error("last-in read wrote stack data");
  a_fifo_oldest: assert property (
    s_r.st == MSTE_ST_EXEC && is_stk && s_r.ph == MSTE_PH_DISP &&
    s_r.c.op == MSTE_OP_FIFO && cnt != 16'h0
    |=> mem.rd && mem.addr == $past(fa))
    else $error("first-in read not at oldest entry");
  a_fifo_shift: assert property (
    s_r.st == MSTE_ST_EXEC && s_r.c.op == MSTE_OP_FIFO &&
    s_r.ph == MSTE_PH_SHD2 |=> mem.wr &&
    mem.addr == $past(s_r.cur) - 32'h1 && mem.wdata == $past(s_r.rdat))
    else $error("entry not shifted toward start");
  a_count_value: assert property (
    done && s_r.c.op == MSTE_OP_COUNT |-> result == {16'h0, cnt})
    else $error("count result wrong");
  a_ir0_load: assert property (
    s_r.st == MSTE_ST_EXEC && is_range && s_r.ph == MSTE_PH_A &&
    s_r.i >= s_r.c.len && s_r.found &&
    !(s_r.c.op inside {MSTE_OP_SUM, MSTE_OP_CSUM})
    |=> result_index_register == $past(s_r.besta) && done)
    else $error("result address not in index register zero");
  a_sum_acc: assert property (
    s_r.st == MSTE_ST_EXEC && s_r.c.op == MSTE_OP_SUM &&
    s_r.ph == MSTE_PH_B
    |=> s_r.acc == $past(s_r.acc) + {16'h0, $past(s_r.rdat)})
    else $error("sum not accumulated");
  a_rec_addr: assert property (
    s_r.st == MSTE_ST_EXEC && s_r.c.op == MSTE_OP_RADR &&
    s_r.c.pos < s_r.rec_cnt && !ir_wr
    |=> s_r.ir[$past(s_r.c.sel)] == $past(s_r.rec_base) +
    32'($past(s_r.c.pos)) * 32'($past(s_r.rec_len)))
    else $error("record start address wrong");
  a_rec_span: assert property (
    done && s_r.c.op == MSTE_OP_RNUM && !err
    |-> s_r.cur <= s_r.ir[s_r.c.sel] &&
    s_r.ir[s_r.c.sel] < s_r.cur + {16'h0, s_r.rec_len} &&
    s_r.cur == s_r.rec_base + 32'(s_r.i) * 32'(s_r.rec_len) &&
    result == {16'h0, s_r.i})
    else $error("record number does not hold address");
  a_table_store: assert property (
    s_r.st == MSTE_ST_EXEC && s_r.c.op == MSTE_OP_RDEF
    |=> s_r.rec_len == $past(s_r.c.len) &&
    s_r.rec_cnt == $past(s_r.c.pos) && done)
    else $error("record table not recorded");
endmodule // mste_engine

// [design/mste_pkg.sv]
// constants and types of the memory stack and table engine
package mste_pkg;
  localparam int MSTE_AW = 32;
  localparam int MSTE_DW = 16;
  localparam int MSTE_NIR = 16;
  // stack region header, word offsets from the region base
  localparam logic [31:0] MSTE_HDR_END_LO = 32'h0;
  localparam logic [31:0] MSTE_HDR_END_HI = 32'h1;
  localparam logic [31:0] MSTE_HDR_PTR = 32'h2;
  localparam logic [31:0] MSTE_HDR_WORDS = 32'h3;
  // sequence steps
  localparam logic [3:0] MSTE_PH_A = 4'h0;
  localparam logic [3:0] MSTE_PH_B = 4'h1;
  localparam logic [3:0] MSTE_PH_C = 4'h2;
  localparam logic [3:0] MSTE_PH_D = 4'h3;
  localparam logic [3:0] MSTE_PH_DISP = 4'h4;
  localparam logic [3:0] MSTE_PH_DEL = 4'h5;
  localparam logic [3:0] MSTE_PH_SHD = 4'h6;
  localparam logic [3:0] MSTE_PH_SHD2 = 4'h7;
  localparam logic [3:0] MSTE_PH_SHU = 4'h8;
  localparam logic [3:0] MSTE_PH_SHU2 = 4'h9;
  localparam logic [3:0] MSTE_PH_PTRW = 4'ha;
  localparam logic [3:0] MSTE_PH_FIN = 4'hb;
  localparam logic [3:0] MSTE_PH_RES = 4'hc;

  typedef enum logic [4:0] {
    MSTE_OP_DEF_STACK = 5'h00, MSTE_OP_PUSH = 5'h01,
    MSTE_OP_FIFO = 5'h02, MSTE_OP_LIFO = 5'h03,
    MSTE_OP_READ = 5'h04, MSTE_OP_WRITE = 5'h05,
    MSTE_OP_INSERT = 5'h06, MSTE_OP_DELETE = 5'h07,
    MSTE_OP_COUNT = 5'h08, MSTE_OP_FIND = 5'h09,
    MSTE_OP_MAX = 5'h0a, MSTE_OP_MIN = 5'h0b,
    MSTE_OP_SUM = 5'h0c, MSTE_OP_CSUM = 5'h0d,
    MSTE_OP_RDEF = 5'h0e, MSTE_OP_RADR = 5'h0f,
    MSTE_OP_RNUM = 5'h10
  } mste_op_t;

  typedef enum logic [5:0] {
    MSTE_ST_IDLE = 6'h01, MSTE_ST_RD = 6'h02, MSTE_ST_CAP = 6'h04,
    MSTE_ST_EXEC = 6'h08, MSTE_ST_WR = 6'h10, MSTE_ST_DONE = 6'h20
  } mste_st_t;

  typedef struct packed {
    mste_op_t op;
    logic [31:0] addr;
    logic [31:0] last;
    logic [15:0] len;
    logic [15:0] pos;
    logic [15:0] data;
    logic [3:0] sel;
  } mste_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [15:0] wdata;
  } mste_mem_t;

  typedef struct packed {
    mste_st_t st;
    mste_cmd_t c;
    logic [3:0] ph;
    logic [31:0] endaddr;
    logic [15:0] ptr;
    logic [31:0] cur;
    logic [15:0] i;
    logic [31:0] acc;
    logic [15:0] best;
    logic [31:0] besta;
    logic found;
    logic err;
    logic [31:0] result;
    logic [31:0] maddr;
    logic [15:0] mwd;
    logic [15:0] rdat;
    logic [31:0] rec_base;
    logic [15:0] rec_len;
    logic [15:0] rec_cnt;
    logic [MSTE_NIR-1:0][MSTE_AW-1:0] ir;
  } mste_state_t;

  localparam mste_state_t MSTE_STATE_RST = '{st: MSTE_ST_IDLE, default: '0};
endpackage

// [design/mste_unused_placeholder_removed.sv]
// intentionally no content beyond this header line

// [verif/memory_stack_table_engine_tb.sv]
// self-checking testbench of the memory stack and table engine
`timescale 1ns/10ps
module memory_stack_table_engine_tb;
  import mste_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  mste_cmd_t cmd = '0;
  mste_mem_t mem;
  logic [15:0] mem_rdata = 16'h0;
  logic ir_wr = 1'b0;
  logic [3:0] ir_wr_sel = 4'h0;
  logic [31:0] ir_wr_data = 32'h0;
  logic [3:0] ir_rd_sel = 4'h0;
  logic [31:0] ir_rd_data;
  logic [31:0] result_index_register;
  logic done;
  logic err;
  logic [31:0] result;
  logic [15:0] mem_arr [0:255];
  int n_mismatch = 0;
  int num_checks = 0;

  always #2 core_clk = ~core_clk;

  mste_engine dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .mem(mem), .mem_rdata(mem_rdata),
    .ir_wr(ir_wr), .ir_wr_sel(ir_wr_sel), .ir_wr_data(ir_wr_data),
    .ir_rd_sel(ir_rd_sel), .ir_rd_data(ir_rd_data),
    .result_index_register(result_index_register), .done(done), .err(err),
    .result(result));

  // word memory; idle read data toggles so a stale sample never matches
  always @(posedge core_clk) begin
    if (mem.wr) mem_arr[mem.addr[7:0]] <= mem.wdata;
    if (mem.rd) mem_rdata <= mem_arr[mem.addr[7:0]];
    else mem_rdata <= ~mem_rdata;
  end

  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
      n_mismatch++;
    end
  endtask

  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one command, held until taken, then waits for done and checks err
  task go(input mste_op_t o, input logic [31:0] a, input logic [31:0] l,
          input logic [15:0] n, input logic [15:0] p, input logic [15:0] d,
          input logic [3:0] s, input logic e);
    int k;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: o, addr: a, last: l, len: n, pos: p, data: d, sel: s};
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (done !== 1'b1 && k < 3000);
    if (k >= 3000) chk(32'h0, 32'h1);
    chk({31'h0, err}, {31'h0, e});
  endtask

  task t_reset;
    @(negedge core_clk);
    chk({cmd_ready, done, err}, 32'h4);
    chk(result, 32'h0);
    chk(result_index_register, 32'h0);
  endtask

  task t_define;
    go(MSTE_OP_DEF_STACK, 32'h10, 32'h1e, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(mem_arr[8'h10], 32'h1e);
    chk(mem_arr[8'h11], 32'h0);
    chk(mem_arr[8'h12], 32'h13);
    // region too short to hold the header and one entry
    go(MSTE_OP_DEF_STACK, 32'h40, 32'h41, 16'h0, 16'h0, 16'h0, 4'h0, 1'b1);
  endtask

  task t_push_pop;
    go(MSTE_OP_PUSH, 32'h10, 32'h0, 16'h0, 16'h0, 16'ha1, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h10, 32'h0, 16'h0, 16'h0, 16'hb2, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h10, 32'h0, 16'h0, 16'h0, 16'hc3, 4'h0, 1'b0);
    chk(mem_arr[8'h15], 32'hc3);
    chk(mem_arr[8'h12], 32'h16);
    go(MSTE_OP_COUNT, 32'h10, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'h3);
    go(MSTE_OP_LIFO, 32'h10, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'hc3);
    chk(mem_arr[8'h12], 32'h15);
    chk(mem_arr[8'h15], 32'hc3);
    go(MSTE_OP_FIFO, 32'h10, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'ha1);
    chk(mem_arr[8'h12], 32'h14);
    chk(mem_arr[8'h13], 32'hb2);
    go(MSTE_OP_LIFO, 32'h10, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'hb2);
    // empty stack refuses both kinds of read
    go(MSTE_OP_LIFO, 32'h10, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b1);
    go(MSTE_OP_FIFO, 32'h10, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b1);
  endtask

  task t_full;
    mem_arr[8'h25] = 16'h5a5a;
    go(MSTE_OP_DEF_STACK, 32'h20, 32'h24, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h20, 32'h0, 16'h0, 16'h0, 16'h11, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h20, 32'h0, 16'h0, 16'h0, 16'h22, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h20, 32'h0, 16'h0, 16'h0, 16'h33, 4'h0, 1'b1);
    chk(mem_arr[8'h25], 32'h5a5a);
    chk(mem_arr[8'h22], 32'h25);
  endtask

  task t_entries;
    go(MSTE_OP_DEF_STACK, 32'h30, 32'h3f, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h30, 32'h0, 16'h0, 16'h0, 16'h1, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h30, 32'h0, 16'h0, 16'h0, 16'h2, 4'h0, 1'b0);
    go(MSTE_OP_PUSH, 32'h30, 32'h0, 16'h0, 16'h0, 16'h3, 4'h0, 1'b0);
    go(MSTE_OP_READ, 32'h30, 32'h0, 16'h0, 16'h1, 16'h0, 4'h0, 1'b0);
    chk(result, 32'h2);
    go(MSTE_OP_WRITE, 32'h30, 32'h0, 16'h0, 16'h1, 16'h9, 4'h0, 1'b0);
    chk(mem_arr[8'h34], 32'h9);
    go(MSTE_OP_INSERT, 32'h30, 32'h0, 16'h0, 16'h0, 16'h7, 4'h0, 1'b0);
    chk({mem_arr[8'h33], mem_arr[8'h34]}, 32'h00070001);
    chk(mem_arr[8'h36], 32'h3);
    go(MSTE_OP_DELETE, 32'h30, 32'h0, 16'h0, 16'h2, 16'h0, 4'h0, 1'b0);
    chk(result, 32'h9);
    go(MSTE_OP_COUNT, 32'h30, 32'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'h3);
    go(MSTE_OP_READ, 32'h30, 32'h0, 16'h0, 16'h3, 16'h0, 4'h0, 1'b1);
  endtask

  task t_range;
    mem_arr[8'h40] = 16'h5;
    mem_arr[8'h41] = 16'h20;
    mem_arr[8'h42] = 16'h3;
    mem_arr[8'h43] = 16'h20;
    mem_arr[8'h44] = 16'h1;
    go(MSTE_OP_FIND, 32'h40, 32'h0, 16'h5, 16'h0, 16'h20, 4'h0, 1'b0);
    chk(result_index_register, 32'h41);
    go(MSTE_OP_MIN, 32'h40, 32'h0, 16'h5, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result_index_register, 32'h44);
    go(MSTE_OP_MAX, 32'h40, 32'h0, 16'h5, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result_index_register, 32'h41);
    go(MSTE_OP_SUM, 32'h40, 32'h0, 16'h5, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'h49);
    go(MSTE_OP_CSUM, 32'h40, 32'h0, 16'h5, 16'h0, 16'h0, 4'h0, 1'b0);
    chk(result, 32'h7);
    go(MSTE_OP_FIND, 32'h40, 32'h0, 16'h5, 16'h0, 16'h77, 4'h0, 1'b1);
  endtask

  task ir_put(input logic [3:0] s, input logic [31:0] v);
    @(posedge core_clk);
    ir_wr <= 1'b1;
    ir_wr_sel <= s;
    ir_wr_data <= v;
    ir_rd_sel <= s;
    @(posedge core_clk);
    ir_wr <= 1'b0;
  endtask

  task t_records;
    ir_put(4'hf, 32'hdeadbeef);
    @(negedge core_clk);
    chk(ir_rd_data, 32'hdeadbeef);
    go(MSTE_OP_RDEF, 32'h80, 32'h0, 16'h4, 16'h3, 16'h0, 4'h0, 1'b0);
    go(MSTE_OP_RADR, 32'h0, 32'h0, 16'h0, 16'h2, 16'h0, 4'h5, 1'b0);
    @(posedge core_clk);
    ir_rd_sel <= 4'h5;
    @(negedge core_clk);
    chk(ir_rd_data, 32'h88);
    ir_put(4'h5, 32'h8a);
    go(MSTE_OP_RNUM, 32'h0, 32'h0, 16'h0, 16'h0, 16'h0, 4'h5, 1'b0);
    chk(result, 32'h2);
    go(MSTE_OP_RADR, 32'h0, 32'h0, 16'h0, 16'h3, 16'h0, 4'h5, 1'b1);
    ir_put(4'h6, 32'h8c);
    go(MSTE_OP_RNUM, 32'h0, 32'h0, 16'h0, 16'h0, 16'h0, 4'h6, 1'b1);
  endtask

  initial begin
    for (int j = 0; j < 256; j++) mem_arr[j] = 16'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_define();
    t_push_pop();
    t_full();
    t_entries();
    t_range();
    t_records();
    report_and_stop();
  end

  // whole run is under a thousand cycles; this is far beyond it
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // memory_stack_table_engine_tb
